// ==== common/acr_pkg.sv ====
// constants, types and field layout of the afe configuration registers
// Operation
// RULE_01: test-signal register at 02h, reset 00h, bits7:5 high
// RULE_02: test-signal bit 4 picks internal or external source
// RULE_03: test-signal bit 2 doubles calibration amplitude
// RULE_04: bits 1:0 pick pulse rate or dc
// RULE_05: reserved test bit 3, reference bit 4 read zero
// RULE_06: reference register at 03h, reset e8, bits7:6 high
// RULE_07: reference bit 5 selects 4 V over 2.4 V
// RULE_08: reference bit 3 routes op-amp noninverting input
// RULE_09: reference bit 2 powers op amp, resets zero
// RULE_10: reserved reference bit 1 always reads zero
// RULE_11: reference bit 0 read-only, value unfixed
// RULE_12: fault register at 04h, threshold in bits 7:5
// RULE_13: threshold code sets paired high/low comparator limits
// RULE_14: read-only bit ignores writes, others store
package acr_pkg;

	// register indices; byte address is four times the index
	localparam logic [7:0] IDX_TEST  = 8'h02;
	localparam logic [7:0] IDX_REF   = 8'h03;
	localparam logic [7:0] IDX_FAULT = 8'h04;

	// reset values of the whole registers
	localparam logic [7:0] RST_TEST  = 8'h00;
	localparam logic [7:0] RST_REF   = 8'he8;
	localparam logic [7:0] RST_FAULT = 8'h00;

	// test-signal register fields
	localparam int TEST_SRC_BIT  = 4;
	localparam int TEST_AMP_BIT  = 2;
	localparam int TEST_RATE_LSB = 0;
	localparam logic [7:0] TEST_ONES_MASK = 8'he0;

	// reference register fields
	localparam int REF_HIGH_BIT  = 5;
	localparam int REF_BIAS_BIT  = 3;
	localparam int REF_POWER_BIT = 2;
	localparam int REF_RO_BIT    = 0;
	localparam logic [7:0] REF_ONES_MASK = 8'hc0;

	// fault register fields
	localparam int FAULT_TH_LSB = 5;

	// test-rate encodings
	localparam logic [1:0] RATE_SLOW   = 2'h0;
	localparam logic [1:0] RATE_FAST   = 2'h1;
	localparam logic [1:0] RATE_UNUSED = 2'h2;
	localparam logic [1:0] RATE_DC     = 2'h3;

	// test pulse periods as powers of two of the master clock
	localparam int SLOW_LOG2 = 21;
	localparam int FAST_LOG2 = 20;

	// comparator limits are given in tenths of a percent
	localparam logic [9:0] FULL_SCALE = 10'h3e8;

	// ahb transfer type bit that marks an active transfer
	localparam int HTRANS_ACTIVE_BIT = 1;

	typedef struct packed {
		logic       test_internal;
		logic       test_amp_double;
		logic [1:0] test_rate_select;
		logic       reference_high_select;
		logic       amp_bias_select;
		logic       amp_power_on;
		logic [2:0] comparator_threshold;
	} acr_cfg_t;

	typedef struct packed {
		logic [7:0] index;
		logic       write;
	} acr_req_t;

endpackage

// ==== logic/acr_test_gen.sv ====
// test-signal waveform generator driven by the master clock
`timescale 1ns/1ps
module acr_test_gen #(
	parameter int SLOW_LOG2 = acr_pkg::SLOW_LOG2,
	parameter int FAST_LOG2 = acr_pkg::FAST_LOG2
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	input  wire logic       ce,
	// control
	input  wire logic       run,
	input  wire logic [1:0] rate,
	// waveform
	output logic            wave
);

	logic [SLOW_LOG2-1:0] cnt_q;
	logic                 wave_d;

	// divider counts while run is high and clears while run is low; each tap toggles at half its pulse period
	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			cnt_q <= '0;
		else if (ce)
		begin
			if (run)
				cnt_q <= cnt_q + 1'b1;
			else
				cnt_q <= '0;
		end
	end

	always_comb
	begin
		case (rate)
			acr_pkg::RATE_SLOW:   wave_d = cnt_q[SLOW_LOG2-1]; // RULE_04
			acr_pkg::RATE_FAST:   wave_d = cnt_q[FAST_LOG2-1]; // RULE_04
			acr_pkg::RATE_DC:     wave_d = 1'b1; // RULE_04
			default:              wave_d = 1'b0;
		endcase
	end

	always_ff @(posedge clk or posedge rst)
	begin
		if (rst)
			wave <= 1'b0;
		else if (ce)
			wave <= run & wave_d;
	end

endmodule // acr_test_gen

// ==== logic/acr_regs.sv ====
// configuration register bank with an ahb-lite slave port
`timescale 1ns/1ps
module acr_regs #(
	parameter int SLOW_LOG2 = acr_pkg::SLOW_LOG2,
	parameter int FAST_LOG2 = acr_pkg::FAST_LOG2
) (
	// clock, reset, enable
	input  wire logic              MCLK,
	input  wire logic              RST,
	input  wire logic              CE,
	// ahb-lite slave
	input  wire logic              HSEL,
	input  wire logic [31:0]       HADDR,
	input  wire logic [1:0]        HTRANS,
	input  wire logic              HWRITE,
	input  wire logic [2:0]        HSIZE,
	input  wire logic [31:0]       HWDATA,
	input  wire logic              HREADY,
	output logic      [31:0]       HRDATA,
	output logic                   HREADYOUT,
	output logic                   HRESP,
	// analog controls
	output acr_pkg::acr_cfg_t      CFG,
	output logic                   TEST_SIGNAL,
	output logic      [9:0]        LIMIT_HIGH,
	output logic      [9:0]        LIMIT_LOW
);

	typedef enum logic [1:0] {
		ST_IDLE,
		ST_WRITE,
		ST_READ
	} acr_state_t;

	acr_state_t        state_q;
	acr_state_t        state_d;
	acr_pkg::acr_req_t req_q;
	logic              take;
	logic              wr_en;
	logic [7:0]        wr_byte;

	// stored register bits; reserved bits are not stored
	logic       src_q;
	logic       amp_q;
	logic [1:0] rate_q;
	logic       ref_high_q;
	logic       bias_q;
	logic       power_q;
	logic [2:0] th_q;

	logic       wave;
	logic [9:0] high_d;

	// high-side comparator limit in tenths of a percent
	function automatic logic [9:0] high_limit(input logic [2:0] code);
		logic [9:0] v;
		v = 10'h3b6;
		case (code)
			3'h0:    v = 10'h3b6;
			3'h1:    v = 10'h39d;
			3'h2:    v = 10'h384;
			3'h3:    v = 10'h36b;
			3'h4:    v = 10'h352;
			3'h5:    v = 10'h320;
			3'h6:    v = 10'h2ee;
			3'h7:    v = 10'h2bc;
			default: v = 10'h3b6;
		endcase
		return v;
	endfunction

	// register index from a byte address; off-word or out of range gives ff
	function automatic logic [7:0] decode(input logic [31:0] addr);
		logic [7:0] idx;
		idx = 8'hff;
		if (addr[1:0] == 2'h0 && addr[31:10] == '0)
			idx = addr[9:2];
		return idx;
	endfunction

	// value seen by a read of the given index
	function automatic logic [7:0] readback(input logic [7:0] idx,
		input logic s, input logic a, input logic [1:0] r,
		input logic h, input logic b, input logic p, input logic [2:0] t);
		logic [7:0] v;
		v = 8'h00;
		case (idx)
			acr_pkg::IDX_TEST:
			begin
				v = acr_pkg::TEST_ONES_MASK; // RULE_01
				v[acr_pkg::TEST_SRC_BIT] = s;
				v[acr_pkg::TEST_AMP_BIT] = a;
				v[acr_pkg::TEST_RATE_LSB +: 2] = r;
				// bit 3 left low RULE_05
			end
			acr_pkg::IDX_REF:
			begin
				v = acr_pkg::REF_ONES_MASK; // RULE_06
				v[acr_pkg::REF_HIGH_BIT] = h;
				v[acr_pkg::REF_BIAS_BIT] = b;
				v[acr_pkg::REF_POWER_BIT] = p;
				// bits 4 and 1 left low RULE_10
				// bit 0 read-only, returns low RULE_11
			end
			acr_pkg::IDX_FAULT:
			begin
				v[acr_pkg::FAULT_TH_LSB +: 3] = t; // RULE_12
			end
			default:
				v = 8'h00;
		endcase
		return v;
	endfunction

	assign take = HSEL & HTRANS[acr_pkg::HTRANS_ACTIVE_BIT] & HREADY;
	assign wr_en = CE & (state_q == ST_WRITE) & req_q.write;
	assign wr_byte = HWDATA[7:0];

	// bus sequencer: writes finish at once, reads take one wait state
	always_comb
	begin
		state_d = state_q;
		case (state_q)
			ST_IDLE,
			ST_WRITE:
			begin
				if (take)
					state_d = HWRITE ? ST_WRITE : ST_READ;
				else
					state_d = ST_IDLE;
			end
			ST_READ:
				state_d = ST_IDLE;
			default:
				state_d = ST_IDLE;
		endcase
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			state_q <= ST_IDLE;
		else if (CE)
			state_q <= state_d;
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			req_q <= '0;
		else if (CE && take)
		begin
			req_q.index <= decode(HADDR);
			req_q.write <= HWRITE;
		end
	end

	// wait state is inserted in the cycle after a read is accepted
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			HREADYOUT <= 1'b1;
		else if (CE)
			HREADYOUT <= !(take && !HWRITE && state_q != ST_READ);
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			HRESP <= 1'b0;
		else if (CE)
			HRESP <= 1'b0;
	end

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			HRDATA <= '0;
		else if (CE)
		begin
			if (state_q == ST_READ)
				HRDATA <= {24'h000000, readback(req_q.index, src_q,
					amp_q, rate_q, ref_high_q, bias_q, power_q, th_q)};
			else
				HRDATA <= '0;
		end
	end

	// test-signal register
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			src_q  <= acr_pkg::RST_TEST[acr_pkg::TEST_SRC_BIT]; // RULE_01
			amp_q  <= acr_pkg::RST_TEST[acr_pkg::TEST_AMP_BIT];
			rate_q <= acr_pkg::RST_TEST[acr_pkg::TEST_RATE_LSB +: 2];
		end
		else if (wr_en && req_q.index == acr_pkg::IDX_TEST)
		begin
			src_q  <= wr_byte[acr_pkg::TEST_SRC_BIT]; // RULE_02
			amp_q  <= wr_byte[acr_pkg::TEST_AMP_BIT]; // RULE_03
			rate_q <= wr_byte[acr_pkg::TEST_RATE_LSB +: 2]; // RULE_04
		end
	end

	// reference register; bit 0 has no storage, so writes to it vanish
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			ref_high_q <= acr_pkg::RST_REF[acr_pkg::REF_HIGH_BIT]; // RULE_07
			bias_q     <= acr_pkg::RST_REF[acr_pkg::REF_BIAS_BIT]; // RULE_06
			power_q    <= acr_pkg::RST_REF[acr_pkg::REF_POWER_BIT]; // RULE_09
		end
		else if (wr_en && req_q.index == acr_pkg::IDX_REF)
		begin
			ref_high_q <= wr_byte[acr_pkg::REF_HIGH_BIT]; // RULE_07
			bias_q     <= wr_byte[acr_pkg::REF_BIAS_BIT]; // RULE_08
			power_q    <= wr_byte[acr_pkg::REF_POWER_BIT]; // RULE_09
		end // RULE_14
	end

	// fault threshold register
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			th_q <= acr_pkg::RST_FAULT[acr_pkg::FAULT_TH_LSB +: 3]; // RULE_12
		else if (wr_en && req_q.index == acr_pkg::IDX_FAULT)
			th_q <= wr_byte[acr_pkg::FAULT_TH_LSB +: 3]; // RULE_12
	end

	// analog control outputs, one cycle behind the stored bits
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			CFG <= '0;
		else if (CE)
		begin
			CFG.test_internal         <= src_q; // RULE_02
			CFG.test_amp_double       <= amp_q; // RULE_03
			CFG.test_rate_select      <= rate_q; // RULE_04
			CFG.reference_high_select <= ref_high_q; // RULE_07
			CFG.amp_bias_select       <= bias_q; // RULE_08
			CFG.amp_power_on          <= power_q; // RULE_09
			CFG.comparator_threshold  <= th_q; // RULE_13
		end
	end

	assign high_d = high_limit(th_q);

	// paired limits: low side mirrors high side about mid-scale
	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
		begin
			LIMIT_HIGH <= 10'h000;
			LIMIT_LOW  <= 10'h000;
		end
		else if (CE)
		begin
			LIMIT_HIGH <= high_d; // RULE_13
			LIMIT_LOW  <= acr_pkg::FULL_SCALE - high_d; // RULE_13
		end
	end

	// internal generator runs only when the source is internal
	acr_test_gen #(
		.SLOW_LOG2 (SLOW_LOG2),
		.FAST_LOG2 (FAST_LOG2)
	) u_gen (
		.clk  (MCLK),
		.rst  (RST),
		.ce   (CE),
		.run  (src_q),
		.rate (rate_q),
		.wave (wave)
	);

	always_ff @(posedge MCLK or posedge RST)
	begin
		if (RST)
			TEST_SIGNAL <= 1'b0;
		else if (CE)
			TEST_SIGNAL <= wave; // RULE_02
	end

endmodule // acr_regs

// ==== testbench/acr_regs_asserts.sv ====
// concurrent checks on the configuration register bank ports
`timescale 1ns/1ps
module acr_regs_chk (
	// clock and reset
	input wire logic		MCLK,
	input wire logic		RST,
	input wire logic		CE,
	// bus
	input wire logic		HSEL,
	input wire logic [31:0]	HADDR,
	input wire logic [1:0]	HTRANS,
	input wire logic		HWRITE,
	input wire logic [31:0]	HWDATA,
	input wire logic		HREADY,
	input wire logic [31:0]	HRDATA,
	input wire logic		HREADYOUT,
	// analog controls
	input wire acr_pkg::acr_cfg_t	CFG,
	input wire logic		TEST_SIGNAL,
	input wire logic [9:0]	LIMIT_HIGH,
	input wire logic [9:0]	LIMIT_LOW
);
	default clocking @(posedge MCLK); endclocking
	default disable iff (RST);
	logic	rd;
	logic	wr;
	assign rd = HSEL & HTRANS[1] & HREADY & CE & !HWRITE;
	assign wr = HSEL & HTRANS[1] & HREADY & CE & HWRITE;

	property p_test_rd;
		rd && HADDR == 32'h8 |=> ##1 HRDATA[7:5] == 3'h7 && !HRDATA[3];
	endproperty
	a_test_rd: assert property (p_test_rd)
		else $error("test register fixed bits wrong");
	property p_ref_rd;
		rd && HADDR == 32'hc |=> ##1 HRDATA[7:6] == 2'h3
			&& !HRDATA[4] && !HRDATA[1];
	endproperty
	a_ref_rd: assert property (p_ref_rd)
		else $error("reference register fixed bits wrong");
	property p_flt_rd;
		rd && HADDR == 32'h10 |=> ##1 HRDATA[4:0] == 5'h0;
	endproperty
	a_flt_rd: assert property (p_flt_rd)
		else $error("fault register low bits not zero");
	property p_rd_wait;
		rd |=> !HREADYOUT ##1 HREADYOUT && HRDATA[31:8] == 24'h0;
	endproperty
	a_rd_wait: assert property (p_rd_wait)
		else $error("read answer timing wrong");
	property p_lim;
		!$past(RST) |-> LIMIT_HIGH + LIMIT_LOW == 10'h3e8;
	endproperty
	a_lim: assert property (p_lim)
		else $error("limits do not pair");
	property p_pwr_wr;
		wr && HADDR == 32'hc |=> ##2 CFG.amp_power_on == $past(HWDATA[2], 2);
	endproperty
	a_pwr_wr: assert property (p_pwr_wr)
		else $error("power bit not applied");
	property p_dc;
		CFG.test_internal && CFG.test_rate_select == 2'h3 [*3] |-> TEST_SIGNAL;
	endproperty
	a_dc: assert property (p_dc)
		else $error("dc test level missing");
	property p_quiet;
		(!CFG.test_internal || CFG.test_rate_select == 2'h2) [*3]
			|-> !TEST_SIGNAL;
	endproperty
	a_quiet: assert property (p_quiet)
		else $error("test signal active while off");

	c_ref_wr: cover property (wr && HADDR == 32'hc);
	c_fast: cover property (CFG.test_internal && CFG.test_rate_select == 2'h1);
	c_flt_rd: cover property (rd && HADDR == 32'h10);
endmodule // acr_regs_chk

bind acr_regs acr_regs_chk u_chk (.MCLK, .RST, .CE, .HSEL, .HADDR, .HTRANS,
	.HWRITE, .HWDATA, .HREADY, .HRDATA, .HREADYOUT, .CFG, .TEST_SIGNAL,
	.LIMIT_HIGH, .LIMIT_LOW);

// ==== testbench/test_afe_config_test_ref_fault_regs.sv ====
// self-checking bench for the afe configuration register bank
`timescale 1ns/1ps
module test_afe_config_test_ref_fault_regs;
	logic			MCLK;
	logic			RST;
	logic			CE;
	logic			HSEL;
	logic			HWRITE;
	logic			HREADYOUT;
	logic			HRESP;
	logic			TEST_SIGNAL;
	logic			b;
	logic [1:0]		HTRANS;
	logic [31:0]	HADDR;
	logic [31:0]	HWDATA;
	logic [31:0]	HRDATA;
	logic [31:0]	r;
	logic [9:0]		LIMIT_HIGH;
	logic [9:0]		LIMIT_LOW;
	logic [9:0]		hi_tab [8];
	acr_pkg::acr_cfg_t	CFG;
	int				error_cnt;
	int				checks_done;
	int				cyc;
	int				tog;

	acr_regs #(.SLOW_LOG2(5), .FAST_LOG2(4)) u_dut (.MCLK, .RST, .CE,
		.HSEL, .HADDR, .HTRANS, .HWRITE, .HSIZE(3'h2), .HWDATA,
		.HREADY(HREADYOUT), .HRDATA, .HREADYOUT, .HRESP, .CFG, .TEST_SIGNAL,
		.LIMIT_HIGH, .LIMIT_LOW);

	initial
	begin
		MCLK = 1'b0;
		forever #50 MCLK = ~MCLK;
	end

	always @(posedge MCLK)
	begin
		cyc <= cyc + 1;
		if (cyc == 5000)
		begin
			error_cnt++;
			complete_run();
		end
	end

	task complete_run;
		$display("checks %0d mismatches %0d", checks_done, error_cnt);
		if (error_cnt == 0 && checks_done > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	task chk(input logic [31:0] g, input logic [31:0] e);
		checks_done++;
		if (g !== e)
		begin
			error_cnt++;
			$display("[FAIL] t=%0t got=%h exp=%h", $time, g, e);
		end
	endtask

	// one single ahb transfer; read data lands in r
	task xf(input logic w, input logic [31:0] a, input logic [31:0] d);
		HSEL <= 1'b1;
		HTRANS <= 2'h2;
		HADDR <= a;
		HWRITE <= w;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		HSEL <= 1'b0;
		HTRANS <= 2'h0;
		HWDATA <= d;
		do @(posedge MCLK); while (HREADYOUT !== 1'b1);
		r = HRDATA;
	endtask

	task rst_dut;
		RST <= 1'b1;
		repeat (3) @(posedge MCLK);
		RST <= 1'b0;
		@(posedge MCLK);
	endtask

	initial
	begin
		RST = 1'b1;
		CE = 1'b1;
		HSEL = 1'b0;
		HWRITE = 1'b0;
		HTRANS = 2'h0;
		HADDR = 32'h0;
		HWDATA = 32'h0;
		cyc = 0;
		hi_tab = '{10'h3b6, 10'h39d, 10'h384, 10'h36b,
			10'h352, 10'h320, 10'h2ee, 10'h2bc};
		rst_dut();
		xf(1'b0, 32'h8, 32'h0);
		chk(r, 32'he0);
		xf(1'b0, 32'hc, 32'h0);
		chk(r, 32'he8);
		xf(1'b0, 32'h10, 32'h0);
		chk(r, 32'h0);
		chk({22'h0, CFG}, 32'h30);
		chk({22'h0, LIMIT_HIGH}, 32'h3b6);
		$display("done: reset values");
		xf(1'b1, 32'h8, 32'h1f);
		xf(1'b0, 32'h8, 32'h0);
		chk(r, 32'hf7);
		chk({22'h0, CFG}, 32'h3f0);
		xf(1'b1, 32'h8, 32'h0);
		xf(1'b0, 32'h8, 32'h0);
		chk(r, 32'he0);
		xf(1'b1, 32'hc, 32'hff);
		xf(1'b0, 32'hc, 32'h0);
		chk(r, 32'hec);
		chk({22'h0, CFG}, 32'h38);
		xf(1'b1, 32'hc, 32'h0);
		xf(1'b0, 32'hc, 32'h0);
		chk(r, 32'hc0);
		chk({22'h0, CFG}, 32'h0);
		$display("done: field storage");
		for (int i = 0; i < 8; i++)
		begin
			xf(1'b1, 32'h10, {24'h0, i[2:0], 5'h1f});
			xf(1'b0, 32'h10, 32'h0);
			chk(r, {24'h0, i[2:0], 5'h0});
			chk({22'h0, LIMIT_HIGH}, {22'h0, hi_tab[i]});
			chk({22'h0, LIMIT_LOW}, 32'h3e8 - hi_tab[i]);
		end
		// with the enable low a write must not land and limits must hold
		CE <= 1'b0;
		xf(1'b1, 32'h10, 32'h0);
		CE <= 1'b1;
		xf(1'b0, 32'h10, 32'h0);
		chk(r, 32'he0);
		chk({22'h0, LIMIT_HIGH}, 32'h2bc);
		$display("done: thresholds");
		xf(1'b1, 32'h14, 32'hff);
		chk({31'h0, HRESP}, 32'h0);
		xf(1'b0, 32'h14, 32'h0);
		chk(r, 32'h0);
		chk({31'h0, HRESP}, 32'h0);
		xf(1'b0, 32'h9, 32'h0);
		chk(r, 32'h0);
		xf(1'b0, 32'h10, 32'h0);
		chk(r, 32'he0);
		$display("done: unmapped");
		for (int m = 0; m < 4; m++)
		begin
			xf(1'b1, 32'h8, 32'h10 | m);
			repeat (6) @(posedge MCLK);
			tog = 0;
			repeat (64)
			begin
				b = TEST_SIGNAL;
				@(posedge MCLK);
				if (TEST_SIGNAL !== b)
					tog++;
			end
			chk(tog, m == 0 ? 4 : m == 1 ? 8 : 0);
			if (m > 1)
				chk({31'h0, TEST_SIGNAL}, {31'h0, m == 3});
		end
		xf(1'b1, 32'h8, 32'h3);
		repeat (6) @(posedge MCLK);
		chk({31'h0, TEST_SIGNAL}, 32'h0);
		$display("done: test signal");
		rst_dut();
		xf(1'b0, 32'hc, 32'h0);
		chk(r, 32'he8);
		$display("done: second reset");
		complete_run();
	end
endmodule // test_afe_config_test_ref_fault_regs
